// ### common/pef_map.svh
`ifndef PEF_MAP_SVH
`define PEF_MAP_SVH

// Special function register byte addresses
`define PEF_ADDR_KEY 8'hC1
`define PEF_ADDR_ADC_START 8'hD8
`define PEF_ADDR_ENABLES 8'hEC
`define PEF_ADDR_PERIPHERAL_SUPPLY_CONFIG 8'hF4
`define PEF_ADDR_BATSW 8'hF5
`define PEF_ADDR_FLAGS 8'hF8
`define PEF_ADDR_INTPIN 8'hFF

// Bit-addressable flag register: bit addresses 0xF8 to 0xFF
`define PEF_FLAG_BIT_BASE 5'h1F

// Unlock value for the interrupt pin configuration register
`define PEF_KEY_UNLOCK 8'hEA

// Acknowledge bit inside the ADC start register
`define PEF_ADC_ACK_BIT 4

// Implemented bits of each register
`define PEF_FLAG_MASK 8'hEF
`define PEF_ENABLE_MASK 8'hAF
`define PEF_INTPIN_MASK 8'hEF

// Flag bit positions
`define PEF_FLAG_RESTORED 7
`define PEF_FLAG_PSM 6
`define PEF_FLAG_SAG 5
`define PEF_FLAG_DC_MEASURE 3
`define PEF_FLAG_BATTERY 2
`define PEF_FLAG_SWITCHOVER 1
`define PEF_FLAG_DC_LOW 0

// Peripheral configuration bit positions
`define PEF_PER_RX_WAKE 7
`define PEF_PER_SOURCE 6
`define PEF_PER_READY 5
`define PEF_PER_PLL_FAULT 4
`define PEF_PER_SLEEP_REF 3

// Reset values of the synchronised analogue conditions
`define PEF_RST_SOURCE 1'b1
`define PEF_RST_READY 1'b1
`define PEF_RST_DC_LOW 1'b0
`define PEF_RST_PLL_LOCK 1'b1
`define PEF_RST_RX_PIN 1'b1

`endif

// ### common/pef_pkg.sv
package pef_pkg;

	typedef enum logic [1:0] {
		PEF_RX_GPIO,
		PEF_RX_SERIAL,
		PEF_RX_SERIAL_WAKE
	} pef_rx_mode_t;

	typedef struct packed {
		logic [7:0] key;
		logic [7:0] intpin;
		logic [7:0] enables;
		logic [1:0] swsel;
		logic sleep_ref;
		logic [1:0] rxfunc;
		logic rx_wake;
		logic pll_fault;
		logic [7:0] rdata;
	} pef_state_t;

endpackage : pef_pkg

// ### core/pef_sync_edge.sv
`include "pef_map.svh"

module pef_sync_edge
	import pef_pkg::*;
#(
	parameter logic RST_VAL = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Asynchronous condition
	input wire logic async_in,
	// Synchronised level and edges
	output logic level,
	output logic rise,
	output logic fall
);

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} pef_sync_t;

	pef_sync_t st;
	pef_sync_t next_st;

	always_comb begin
		next_st.meta = async_in;
		next_st.sync = st.meta;
		next_st.prev = st.sync;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= {RST_VAL, RST_VAL, RST_VAL};
		end else begin
			st <= next_st;
		end
	end

	// Edges look only at the second and third stages
	assign level = st.sync;
	assign rise = st.sync & ~st.prev;
	assign fall = ~st.sync & st.prev;

endmodule : pef_sync_edge

// ### core/pef_flag_reg.sv
`include "pef_map.svh"

module pef_flag_reg
	import pef_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] MASK = '1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Software write
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	// Hardware events
	input wire logic [WIDTH-1:0] set,
	// Sticky flags
	output logic [WIDTH-1:0] flags
);

	typedef struct packed {
		logic [WIDTH-1:0] flags;
	} pef_flag_t;

	pef_flag_t st;
	pef_flag_t next_st;

	always_comb begin
		next_st = st;
		if (wr_en) begin
			next_st.flags = wr_data;
		end
		// Set beats a simultaneous clear so no event is lost
		next_st.flags = (next_st.flags | set) & MASK;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign flags = st.flags;

endmodule : pef_flag_reg

// ### core/pef_ctrl.sv
// Summary of operation
// - Pin config writes need key 0xEA
// - Set restored flag on battery-to-main change
// - Set power-state flag on enabled event
// - Set sag flag on voltage sag
// - Set dc measure flag on change/ready
// - Set battery flag on low/ready
// - Set switchover flag on main-to-battery change
// - Set dc low flag below threshold
// - Decode switchover select field
// - Set receive-wake flag on deep-sleep wake edge
// - Report supply source, reset one
// - Report main supply ready, reset one
// - PLL fault set on unlock, ack clears
// - Keep reference on in deepest sleep
// - Decode receive pin function field
// - Interrupt only from enabled flags
`include "pef_map.svh"

module pef_ctrl
	import pef_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Special function register byte access
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Special function register bit access
	input wire logic sfr_bit_wr,
	input wire logic [7:0] sfr_bit_addr,
	input wire logic sfr_bit_data,
	// Analogue conditions, asynchronous
	input wire logic supply_on_main,
	input wire logic main_supply_ready,
	input wire logic dc_input_low,
	input wire logic pll_locked,
	input wire logic rx_pin,
	// Measurement events, core clock pulses
	input wire logic voltage_sag_event,
	input wire logic dc_measure_event,
	input wire logic battery_event,
	// Power mode, core clock level
	input wire logic deepest_sleep_mode,
	// Interrupt
	output logic power_irq,
	// Configuration outputs
	output logic [7:0] interrupt_pin_config,
	output logic sw_on_low_main,
	output logic sw_on_low_dc_input,
	output logic sw_disabled,
	output logic rx_sel_gpio,
	output logic rx_sel_serial,
	output logic rx_wake_enable,
	output logic sleep_reference_enable
);

	pef_state_t st;
	pef_state_t next_st;

	logic src_level;
	logic src_rise;
	logic src_fall;
	logic ready_level;
	logic dcl_level;
	logic dcl_rise;
	logic pll_level;
	logic pll_fall;
	logic rx_level;
	logic rx_rise;
	logic rx_fall;

	logic [7:0] flags;
	logic [7:0] raw_events;
	logic [7:0] flag_set;
	logic [7:0] flag_wdata;
	logic [7:0] bit_merge;
	logic flag_wr;
	logic bit_hit;
	logic psm_event;
	logic adc_ack;
	logic rx_edge;
	logic wr_intpin;
	logic [7:0] peripheral_supply_config_read;
	pef_rx_mode_t rx_mode;

	function automatic pef_rx_mode_t decode_rx(input logic [1:0] code);
		pef_rx_mode_t m;
		m = PEF_RX_GPIO;
		unique case (code)
			2'h0: m = PEF_RX_GPIO;
			2'h1: m = PEF_RX_SERIAL;
			2'h3: m = PEF_RX_SERIAL_WAKE;
			// Undefined code falls back to plain I/O
			default: m = PEF_RX_GPIO;
		endcase
		return m;
	endfunction : decode_rx

	// Analogue conditions cross into the core clock here
	pef_sync_edge #(.RST_VAL(`PEF_RST_SOURCE)) u_src (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(supply_on_main),
		.level(src_level),
		.rise(src_rise),
		.fall(src_fall)
	);

	pef_sync_edge #(.RST_VAL(`PEF_RST_READY)) u_ready (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(main_supply_ready),
		.level(ready_level),
		.rise(),
		.fall()
	);

	pef_sync_edge #(.RST_VAL(`PEF_RST_DC_LOW)) u_dcl (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(dc_input_low),
		.level(dcl_level),
		.rise(dcl_rise),
		.fall()
	);

	// Reset as locked so release of reset raises no fault
	pef_sync_edge #(.RST_VAL(`PEF_RST_PLL_LOCK)) u_pll (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(pll_locked),
		.level(pll_level),
		.rise(),
		.fall(pll_fall)
	);

	pef_sync_edge #(.RST_VAL(`PEF_RST_RX_PIN)) u_rx (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(rx_pin),
		.level(rx_level),
		.rise(rx_rise),
		.fall(rx_fall)
	);

	// Raw conditions at their flag positions; bit 6 is derived
	assign raw_events = {src_rise, 1'b0, voltage_sag_event, 1'b0,
		dc_measure_event, battery_event, src_fall, dcl_rise};
	assign psm_event = |(raw_events & st.enables & `PEF_ENABLE_MASK);
	assign flag_set = raw_events | {1'b0, psm_event, 6'h00};

	assign bit_hit = sfr_bit_wr && (sfr_bit_addr[7:3] == `PEF_FLAG_BIT_BASE);
	assign bit_merge = (flags & ~(8'h01 << sfr_bit_addr[2:0]))
		| ({7'h00, sfr_bit_data} << sfr_bit_addr[2:0]);
	assign flag_wr = (sfr_wr && sfr_addr == `PEF_ADDR_FLAGS) || bit_hit;
	assign flag_wdata = bit_hit ? bit_merge : sfr_wdata;

	pef_flag_reg #(.WIDTH(8), .MASK(`PEF_FLAG_MASK)) u_flags (
		.clk(clk),
		.reset_n(reset_n),
		.wr_en(flag_wr),
		.wr_data(flag_wdata),
		.set(flag_set),
		.flags(flags)
	);

	assign wr_intpin = sfr_wr && sfr_addr == `PEF_ADDR_INTPIN;
	// The ADC start register lives elsewhere; only its ack bit is watched
	assign adc_ack = sfr_wr && sfr_addr == `PEF_ADDR_ADC_START
		&& sfr_wdata[`PEF_ADC_ACK_BIT];
	assign rx_mode = decode_rx(st.rxfunc);
	assign rx_edge = rx_rise | rx_fall;
	assign peripheral_supply_config_read = {st.rx_wake, src_level, ready_level, st.pll_fault,
		st.sleep_ref, 1'b0, st.rxfunc};

	always_comb begin
		next_st = st;
		if (sfr_wr) begin
			case (sfr_addr)
				`PEF_ADDR_KEY: next_st.key = sfr_wdata;
				`PEF_ADDR_INTPIN: begin
					if (st.key == `PEF_KEY_UNLOCK) begin
						next_st.intpin = sfr_wdata & `PEF_INTPIN_MASK;
					end
				end
				`PEF_ADDR_ENABLES: next_st.enables = sfr_wdata & `PEF_ENABLE_MASK;
				`PEF_ADDR_BATSW: next_st.swsel = sfr_wdata[1:0];
				`PEF_ADDR_PERIPHERAL_SUPPLY_CONFIG: begin
					next_st.sleep_ref = sfr_wdata[`PEF_PER_SLEEP_REF];
					next_st.rxfunc = sfr_wdata[1:0];
					// Wake flag can only be cleared by software
					if (!sfr_wdata[`PEF_PER_RX_WAKE]) begin
						next_st.rx_wake = 1'b0;
					end
				end
				default: ;
			endcase
		end
		if (adc_ack) begin
			next_st.pll_fault = 1'b0;
		end
		// Hardware sets come last so they win over a clear
		if (pll_fall) begin
			next_st.pll_fault = 1'b1;
		end
		if (rx_edge && rx_mode == PEF_RX_SERIAL_WAKE && deepest_sleep_mode) begin
			next_st.rx_wake = 1'b1;
		end
		case (sfr_addr)
			`PEF_ADDR_KEY: next_st.rdata = st.key;
			`PEF_ADDR_INTPIN: next_st.rdata = st.intpin;
			`PEF_ADDR_ENABLES: next_st.rdata = st.enables;
			`PEF_ADDR_BATSW: next_st.rdata = {6'h00, st.swsel};
			`PEF_ADDR_PERIPHERAL_SUPPLY_CONFIG: next_st.rdata = peripheral_supply_config_read;
			`PEF_ADDR_FLAGS: next_st.rdata = flags;
			default: next_st.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign sfr_rdata = st.rdata;
	assign power_irq = |(flags & st.enables & `PEF_ENABLE_MASK);
	assign interrupt_pin_config = st.intpin;
	assign sw_on_low_main = !st.swsel[1];
	assign sw_on_low_dc_input = st.swsel == 2'h1;
	assign sw_disabled = st.swsel[1];
	assign rx_sel_gpio = rx_mode == PEF_RX_GPIO;
	assign rx_sel_serial = rx_mode != PEF_RX_GPIO;
	assign rx_wake_enable = rx_mode == PEF_RX_SERIAL_WAKE;
	assign sleep_reference_enable = st.sleep_ref;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	key_gate_a: assert property (wr_intpin && st.key != `PEF_KEY_UNLOCK
		|=> $stable(interrupt_pin_config))
		else $error("Locked write changed pin config");

	key_open_a: assert property (wr_intpin && st.key == `PEF_KEY_UNLOCK
		|=> interrupt_pin_config == ($past(sfr_wdata) & `PEF_INTPIN_MASK))
		else $error("Unlocked write not stored in pin config");

	restore_flag_a: assert property (src_rise |=> flags[`PEF_FLAG_RESTORED])
		else $error("Supply restored flag not set");

	psm_flag_a: assert property (psm_event |=> flags[`PEF_FLAG_PSM])
		else $error("Power-state flag not set on enabled event");

	sag_flag_a: assert property (voltage_sag_event |=> flags[`PEF_FLAG_SAG])
		else $error("Sag flag not set");

	measure_flags_a: assert property (dc_measure_event && battery_event
		|=> flags[`PEF_FLAG_DC_MEASURE] && flags[`PEF_FLAG_BATTERY])
		else $error("Measurement flags not set");

	switch_flag_a: assert property (src_fall |=> flags[`PEF_FLAG_SWITCHOVER])
		else $error("Switchover flag not set");

	dc_low_flag_a: assert property ($rose(dcl_level) |=> flags[`PEF_FLAG_DC_LOW])
		else $error("Dc low flag not set");

	sw_decode_a: assert property (sfr_wr && sfr_addr == `PEF_ADDR_BATSW
		&& sfr_wdata[1:0] == 2'h1 |=> sw_on_low_main && sw_on_low_dc_input && !sw_disabled)
		else $error("Switchover select decode wrong");

	rx_wake_a: assert property (rx_edge && rx_wake_enable && deepest_sleep_mode
		|=> ##1 sfr_rdata[`PEF_PER_RX_WAKE] || $past(sfr_addr) != `PEF_ADDR_PERIPHERAL_SUPPLY_CONFIG)
		else $error("Receive wake flag not reported");

	source_read_a: assert property ($past(sfr_addr) == `PEF_ADDR_PERIPHERAL_SUPPLY_CONFIG
		|-> sfr_rdata[`PEF_PER_SOURCE] == $past(src_level)
		&& sfr_rdata[`PEF_PER_READY] == $past(ready_level))
		else $error("Supply status bits misreported");

	pll_fault_a: assert property (pll_fall |=> st.pll_fault)
		else $error("PLL fault not set on loss of lock");

	pll_ack_a: assert property (adc_ack && !pll_fall |=> !st.pll_fault)
		else $error("PLL fault not cleared by ack");

	rx_decode_a: assert property (sfr_wr && sfr_addr == `PEF_ADDR_PERIPHERAL_SUPPLY_CONFIG
		&& sfr_wdata[1:0] == 2'h0 |=> rx_sel_gpio && !rx_sel_serial && !rx_wake_enable)
		else $error("Receive pin decode wrong");

	irq_hold_a: assert property (power_irq && !flag_wr
		&& !(sfr_wr && sfr_addr == `PEF_ADDR_ENABLES) |=> power_irq)
		else $error("Interrupt dropped without a write");

	irq_masked_a: assert property (st.enables == 8'h00 |-> !power_irq)
		else $error("Interrupt raised with all enables off");

	flag_hold_a: assert property (!flag_wr && flag_set == 8'h00
		|=> $stable(flags))
		else $error("Flags changed without event or write");

	psm_quiet_a: assert property (!psm_event && !flags[`PEF_FLAG_PSM] && !flag_wr
		|=> !flags[`PEF_FLAG_PSM])
		else $error("Power-state flag set without enabled event");

	pll_hold_a: assert property (st.pll_fault && !adc_ack |=> st.pll_fault)
		else $error("PLL fault dropped without ack");

	wake_hold_a: assert property (!st.rx_wake
		&& !(rx_edge && rx_wake_enable && deepest_sleep_mode) |=> !st.rx_wake)
		else $error("Receive wake flag set without wake edge");

	wake_clear_a: assert property (sfr_wr && sfr_addr == `PEF_ADDR_PERIPHERAL_SUPPLY_CONFIG
		&& !sfr_wdata[`PEF_PER_RX_WAKE]
		&& !(rx_edge && rx_wake_enable && deepest_sleep_mode) |=> !st.rx_wake)
		else $error("Receive wake flag not cleared by write");

	sw_off_a: assert property (sfr_wr && sfr_addr == `PEF_ADDR_BATSW
		&& sfr_wdata[1] |=> sw_disabled && !sw_on_low_main && !sw_on_low_dc_input)
		else $error("Switchover disable decode wrong");

	rx_serial_a: assert property (sfr_wr && sfr_addr == `PEF_ADDR_PERIPHERAL_SUPPLY_CONFIG
		&& sfr_wdata[1:0] == 2'h1 |=> rx_sel_serial && !rx_sel_gpio && !rx_wake_enable)
		else $error("Receive serial decode wrong");

	rx_wake_mode_a: assert property (sfr_wr && sfr_addr == `PEF_ADDR_PERIPHERAL_SUPPLY_CONFIG
		&& sfr_wdata[1:0] == 2'h3 |=> rx_sel_serial && !rx_sel_gpio && rx_wake_enable)
		else $error("Receive wake mode decode wrong");

	sleep_ref_a: assert property (sfr_wr && sfr_addr == `PEF_ADDR_PERIPHERAL_SUPPLY_CONFIG
		|=> sleep_reference_enable == $past(sfr_wdata[`PEF_PER_SLEEP_REF]))
		else $error("Sleep reference enable not stored");

	unlock_write_c: cover property (sfr_wr && sfr_addr == `PEF_ADDR_KEY
		&& sfr_wdata == `PEF_KEY_UNLOCK ##1 wr_intpin);
	switchover_irq_c: cover property (src_fall && st.enables[`PEF_FLAG_SWITCHOVER] ##1 power_irq);
	set_beats_clear_c: cover property (flag_wr && |flag_set);
	pll_ack_c: cover property (st.pll_fault ##1 adc_ack ##1 !st.pll_fault);
	psm_raise_c: cover property (psm_event ##1 flags[`PEF_FLAG_PSM]);

endmodule : pef_ctrl

// ### sim/pef_ctrl_bench.sv
module pef_ctrl_bench;
	import pef_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk;
	logic reset_n;
	logic [7:0] sfr_addr;
	logic sfr_wr;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic sfr_bit_wr;
	logic [7:0] sfr_bit_addr;
	logic sfr_bit_data;
	logic supply_on_main;
	logic main_supply_ready;
	logic dc_input_low;
	logic pll_locked;
	logic rx_pin;
	logic voltage_sag_event;
	logic dc_measure_event;
	logic battery_event;
	logic deepest_sleep_mode;
	logic power_irq;
	logic [7:0] interrupt_pin_config;
	logic sw_on_low_main;
	logic sw_on_low_dc_input;
	logic sw_disabled;
	logic rx_sel_gpio;
	logic rx_sel_serial;
	logic rx_wake_enable;
	logic sleep_reference_enable;
	int err_count = 0;
	int check_count = 0;
	logic [7:0] d;

	pef_ctrl pef_ctrl_i (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_bit_wr(sfr_bit_wr),
		.sfr_bit_addr(sfr_bit_addr), .sfr_bit_data(sfr_bit_data),
		.supply_on_main(supply_on_main), .main_supply_ready(main_supply_ready),
		.dc_input_low(dc_input_low), .pll_locked(pll_locked), .rx_pin(rx_pin),
		.voltage_sag_event(voltage_sag_event), .dc_measure_event(dc_measure_event),
		.battery_event(battery_event), .deepest_sleep_mode(deepest_sleep_mode),
		.power_irq(power_irq), .interrupt_pin_config(interrupt_pin_config),
		.sw_on_low_main(sw_on_low_main), .sw_on_low_dc_input(sw_on_low_dc_input),
		.sw_disabled(sw_disabled), .rx_sel_gpio(rx_sel_gpio), .rx_sel_serial(rx_sel_serial),
		.rx_wake_enable(rx_wake_enable), .sleep_reference_enable(sleep_reference_enable));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task tally_and_finish;
		if (err_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : tick

	// Every bus task starts one edge later, so strobes never toggle twice in a step
	task wr(input logic [7:0] a, input logic [7:0] v);
		tick(1);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		tick(1);
		sfr_wr = 1'b0;
	endtask : wr

	task bwr(input logic [7:0] a, input logic v);
		tick(1);
		sfr_bit_addr = a;
		sfr_bit_data = v;
		sfr_bit_wr = 1'b1;
		tick(1);
		sfr_bit_wr = 1'b0;
	endtask : bwr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		tick(1);
		sfr_addr = a;
		tick(1);
		chk(sfr_rdata, exp);
	endtask : rd

	task pulse(input int k);
		tick(1);
		case (k)
			0: voltage_sag_event = 1'b1;
			1: dc_measure_event = 1'b1;
			default: battery_event = 1'b1;
		endcase
		tick(1);
		{voltage_sag_event, dc_measure_event, battery_event} = 3'b000;
	endtask : pulse

	task t_reset;
		rd(8'hF4, 8'h60);
		rd(8'hF8, 8'h00);
		rd(8'hEC, 8'h00);
		rd(8'hF5, 8'h00);
		rd(8'h55, 8'h00);
		chk(8'({sw_on_low_main, sw_on_low_dc_input, sw_disabled, rx_sel_gpio, rx_sel_serial,
			rx_wake_enable, sleep_reference_enable, power_irq}), 8'h90);
	endtask : t_reset

	task t_key;
		wr(8'hFF, 8'h80);
		chk(interrupt_pin_config, 8'h00);
		wr(8'hC1, 8'hEA);
		wr(8'hFF, 8'h9F);
		chk(interrupt_pin_config, 8'h8F);
		wr(8'hC1, 8'h00);
		wr(8'hFF, 8'h00);
		chk(interrupt_pin_config, 8'h8F);
		rd(8'hFF, 8'h8F);
		rd(8'hC1, 8'h00);
	endtask : t_key

	task t_events;
		wr(8'hEC, 8'hEF);
		rd(8'hEC, 8'hAF);
		wr(8'hEC, 8'h00);
		pulse(0);
		rd(8'hF8, 8'h20);
		chk(8'(power_irq), 8'h00);
		wr(8'hEC, 8'h20);
		chk(8'(power_irq), 8'h01);
		bwr(8'hFD, 1'b0);
		rd(8'hF8, 8'h00);
		bwr(8'hF5, 1'b1);
		rd(8'hF8, 8'h00);
		chk(8'(power_irq), 8'h00);
		pulse(0);
		rd(8'hF8, 8'h60);
		wr(8'hF8, 8'h00);
		wr(8'hEC, 8'h0C);
		pulse(1);
		rd(8'hF8, 8'h48);
		wr(8'hF8, 8'h00);
		pulse(2);
		rd(8'hF8, 8'h44);
		chk(8'(power_irq), 8'h01);
		wr(8'hF8, 8'h00);
		wr(8'hEC, 8'h00);
	endtask : t_events

	task t_supply;
		supply_on_main = 1'b0;
		tick(4);
		rd(8'hF8, 8'h02);
		rd(8'hF4, 8'h20);
		supply_on_main = 1'b1;
		tick(4);
		rd(8'hF8, 8'h82);
		wr(8'hF8, 8'h00);
		dc_input_low = 1'b1;
		tick(4);
		rd(8'hF8, 8'h01);
		dc_input_low = 1'b0;
		wr(8'hF8, 8'h00);
		main_supply_ready = 1'b0;
		tick(4);
		rd(8'hF4, 8'h40);
		main_supply_ready = 1'b1;
		tick(4);
	endtask : t_supply

	task t_pll;
		pll_locked = 1'b0;
		tick(4);
		pll_locked = 1'b1;
		tick(4);
		rd(8'hF4, 8'h70);
		wr(8'hD8, 8'h00);
		rd(8'hF4, 8'h70);
		wr(8'hD8, 8'h10);
		rd(8'hF4, 8'h60);
	endtask : t_pll

	task t_decode;
		logic [1:0] i;
		for (int n = 0; n < 4; n++) begin
			i = 2'(n);
			wr(8'hF5, {6'h00, i});
			chk(8'({sw_on_low_main, sw_on_low_dc_input, sw_disabled}),
				8'({~i[1], i == 2'b01, i[1]}));
			wr(8'hF4, {6'h02, i});
			chk(8'({rx_sel_gpio, rx_sel_serial, rx_wake_enable, sleep_reference_enable}),
				8'({~i[0], i[0], i == 2'b11, 1'b1}));
		end
	endtask : t_decode

	task t_rxwake;
		wr(8'hF4, 8'h03);
		rx_pin = 1'b0;
		tick(4);
		rd(8'hF4, 8'h63);
		rx_pin = 1'b1;
		tick(4);
		wr(8'hF4, 8'h01);
		deepest_sleep_mode = 1'b1;
		rx_pin = 1'b0;
		tick(4);
		rd(8'hF4, 8'h61);
		wr(8'hF4, 8'h03);
		rx_pin = 1'b1;
		tick(4);
		deepest_sleep_mode = 1'b0;
		rd(8'hF4, 8'hE3);
		wr(8'hF4, 8'h83);
		rd(8'hF4, 8'hE3);
		wr(8'hF4, 8'h03);
		rd(8'hF4, 8'h63);
	endtask : t_rxwake

	// Watchdog so a stuck run still reaches the verdict
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end

	initial begin
		reset_n = 1'b0;
		sfr_addr = 8'h00;
		sfr_wr = 1'b0;
		sfr_wdata = 8'h00;
		sfr_bit_wr = 1'b0;
		sfr_bit_addr = 8'h00;
		sfr_bit_data = 1'b0;
		supply_on_main = 1'b1;
		main_supply_ready = 1'b1;
		dc_input_low = 1'b0;
		pll_locked = 1'b1;
		rx_pin = 1'b1;
		{voltage_sag_event, dc_measure_event, battery_event} = 3'b000;
		deepest_sleep_mode = 1'b0;
		tick(8);
		reset_n = 1'b1;
		t_reset();
		t_key();
		t_events();
		t_supply();
		t_pll();
		t_decode();
		t_rxwake();
		tally_and_finish();
	end
endmodule : pef_ctrl_bench
